// ===== hw/int_divider_pkg.sv
// Shared constants and carriers for the per-core integer divider.
// Assumes one core-side write/read port per divider instance.
package int_divider_pkg;
   localparam int unsigned WIDTH        = 32;
   localparam int unsigned CALC_CYCLES  = 8;
   localparam logic [3:0]  CNT_RESET    = 4'h0;
   localparam logic [31:0] WORD_RESET   = 32'h0000_0000;
   localparam logic        FLAG_RESET   = 1'h0;
   localparam logic        READY_RESET  = 1'h1;

   // Core-side register select codes
   typedef enum logic [2:0]
   {
      SEL_DIVIDEND_U,
      SEL_DIVISOR_U,
      SEL_DIVIDEND_S,
      SEL_DIVISOR_S,
      SEL_QUOTIENT,
      SEL_REMAINDER,
      SEL_CTRL_STATUS
   } reg_sel_e;

   // One core write access
   typedef struct packed
   {
      logic        valid;
      reg_sel_e    sel;
      logic [31:0] data;
   } core_wr_s;

   // Status word: ready in bit 0, dirty in bit 1
   localparam int unsigned CSR_READY_BIT = 0;
   localparam int unsigned CSR_DIRTY_BIT = 1;

   // Combined result: remainder high, quotient low
   typedef struct packed
   {
      logic [31:0] remainder;
      logic [31:0] quotient;
   } divmod_s;
endpackage

// ===== hw/per_core_int_divider.sv
// Per-core integer divider: quotient and remainder, signed or unsigned.
// Assumes the core drives wr on its own clock, one access per cycle.
`timescale 1ns/1ns
`default_nettype none

module per_core_int_divider
#(
   parameter int unsigned WIDTH       = int_divider_pkg::WIDTH,
   parameter int unsigned CALC_CYCLES = int_divider_pkg::CALC_CYCLES
)
(
   input  wire logic                      clock,
   input  wire logic                      rst,
   input  wire int_divider_pkg::core_wr_s wr,
   output var  logic [31:0]               dividend_q,
   output var  logic [31:0]               divisor_q,
   output var  logic [31:0]               quotient_q,
   output var  logic [31:0]               remainder_q,
   output var  logic [31:0]               ctrl_status_q,
   output var  int_divider_pkg::divmod_s  result_q
);
   localparam int unsigned W = WIDTH;

   logic [31:0] dividend_ff, nxt_dividend;
   logic [31:0] divisor_ff, nxt_divisor;
   logic [31:0] quotient_ff, nxt_quotient;
   logic [31:0] remainder_ff, nxt_remainder;
   logic [3:0]  cnt_ff, nxt_cnt;
   logic        signed_ff, nxt_signed;
   logic        dirty_ff, nxt_dirty;
   logic        ready_ff, nxt_ready;
   logic        op_wr;
   logic        rest_wr;
   logic        div_zero;
   logic [31:0] csr;
   logic [31:0] q_abs;
   logic [31:0] r_abs;
   logic [31:0] a_abs;
   logic [31:0] b_abs;
   logic [31:0] q_fin;
   logic [31:0] r_fin;

   // Magnitude of a word under the chosen interpretation
   function automatic logic [31:0] mag(input logic [31:0] v, input logic s);
      mag = (s && v[31]) ? (32'h0000_0000 - v) : v;
   endfunction

   // Select codes that carry the signed interpretation
   function automatic logic signed_sel(input int_divider_pkg::reg_sel_e s);
      signed_sel = (s == int_divider_pkg::SEL_DIVIDEND_S) ||
                   (s == int_divider_pkg::SEL_DIVISOR_S);
   endfunction

   // Result computed combinationally, exposed only after the count;
   // trades area for an exact, fixed latency.
   always_comb
   begin
      a_abs    = mag(dividend_ff, signed_ff);
      b_abs    = mag(divisor_ff, signed_ff);
      div_zero = (b_abs == 32'h0000_0000);
      if (div_zero)
      begin
         // Divide by zero: all-ones quotient, dividend as remainder
         q_abs = 32'hFFFF_FFFF;
         r_abs = a_abs;
      end
      else
      begin
         q_abs = a_abs / b_abs;
         r_abs = a_abs % b_abs;
      end
      // Sign fix-up: quotient toward zero, remainder takes dividend sign
      q_fin = q_abs;
      r_fin = r_abs;
      if (signed_ff && (dividend_ff[31] ^ divisor_ff[31]) && !div_zero)
      begin
         q_fin = 32'h0000_0000 - q_abs;
      end
      if (signed_ff && dividend_ff[31])
      begin
         r_fin = 32'h0000_0000 - r_abs;
      end
   end

   // Write decode for the control group; the data group decodes wr.sel itself
   always_comb
   begin
      op_wr   = 1'h0;
      rest_wr = 1'h0;
      if (wr.valid)
      begin
         case (wr.sel)
            int_divider_pkg::SEL_DIVIDEND_U,
            int_divider_pkg::SEL_DIVIDEND_S,
            int_divider_pkg::SEL_DIVISOR_U,
            int_divider_pkg::SEL_DIVISOR_S:
            begin
               op_wr = 1'h1;
            end
            int_divider_pkg::SEL_QUOTIENT,
            int_divider_pkg::SEL_REMAINDER:
            begin
               rest_wr = 1'h1;
            end
            default:
            begin
               // Status writes are ignored; ready is owned by hardware
               op_wr = 1'h0;
            end
         endcase
      end
   end

   // Control group: count, ready, signedness, dirty
   always_comb
   begin
      nxt_cnt    = cnt_ff;
      nxt_signed = signed_ff;
      nxt_dirty  = dirty_ff;
      if (cnt_ff != int_divider_pkg::CNT_RESET)
      begin
         nxt_cnt = cnt_ff - 4'h1;
      end
      if (op_wr)
      begin
         // Any operand write restarts the count with both stored words
         nxt_cnt    = 4'(CALC_CYCLES);
         nxt_signed = signed_sel(wr.sel);
         nxt_dirty  = 1'h1;
      end
      else if (rest_wr)
      begin
         // Restoring a result ends any division in flight
         nxt_cnt = int_divider_pkg::CNT_RESET;
      end
      nxt_ready = (nxt_cnt == int_divider_pkg::CNT_RESET);
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         cnt_ff    <= int_divider_pkg::CNT_RESET;
         signed_ff <= int_divider_pkg::FLAG_RESET;
         dirty_ff  <= int_divider_pkg::FLAG_RESET;
         ready_ff  <= int_divider_pkg::READY_RESET;
      end
      else
      begin
         cnt_ff    <= nxt_cnt;
         signed_ff <= nxt_signed;
         dirty_ff  <= nxt_dirty;
         ready_ff  <= nxt_ready;
      end
   end

   // Data group: operand and result words
   always_comb
   begin
      nxt_dividend  = dividend_ff;
      nxt_divisor   = divisor_ff;
      nxt_quotient  = quotient_ff;
      nxt_remainder = remainder_ff;
      // Results land on the last count step; old ones stand until then
      if (cnt_ff == 4'h1)
      begin
         nxt_quotient  = q_fin;
         nxt_remainder = r_fin;
      end
      if (wr.valid)
      begin
         case (wr.sel)
            int_divider_pkg::SEL_DIVIDEND_U,
            int_divider_pkg::SEL_DIVIDEND_S:
            begin
               nxt_dividend = wr.data;
            end
            int_divider_pkg::SEL_DIVISOR_U,
            int_divider_pkg::SEL_DIVISOR_S:
            begin
               nxt_divisor = wr.data;
            end
            int_divider_pkg::SEL_QUOTIENT:
            begin
               nxt_quotient = wr.data;
            end
            int_divider_pkg::SEL_REMAINDER:
            begin
               nxt_remainder = wr.data;
            end
            default:
            begin
               // Status writes leave every word alone
               nxt_dividend = dividend_ff;
            end
         endcase
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         dividend_ff  <= int_divider_pkg::WORD_RESET;
         divisor_ff   <= int_divider_pkg::WORD_RESET;
         quotient_ff  <= int_divider_pkg::WORD_RESET;
         remainder_ff <= int_divider_pkg::WORD_RESET;
      end
      else
      begin
         dividend_ff  <= nxt_dividend;
         divisor_ff   <= nxt_divisor;
         quotient_ff  <= nxt_quotient;
         remainder_ff <= nxt_remainder;
      end
   end

   // Outputs are the registers themselves, so reads cost no extra cycle
   always_comb
   begin
      csr = int_divider_pkg::WORD_RESET;
      csr[int_divider_pkg::CSR_READY_BIT] = ready_ff;
      csr[int_divider_pkg::CSR_DIRTY_BIT] = dirty_ff;
   end

   assign dividend_q         = dividend_ff;
   assign divisor_q          = divisor_ff;
   assign quotient_q         = quotient_ff;
   assign remainder_q        = remainder_ff;
   assign ctrl_status_q      = csr;
   assign result_q.remainder = remainder_ff;
   assign result_q.quotient  = quotient_ff;

   // Count register is four bits, so the latency must fit in it
   if (W != 32)
   begin : g_width_check
      $error("Divider supports only 32-bit operands");
   end
   if ((CALC_CYCLES < 1) || (CALC_CYCLES > 15))
   begin : g_cycles_check
      $error("Divider latency must lie between 1 and 15 cycles");
   end
endmodule // per_core_int_divider

`default_nettype wire

// ===== testbench/core_model.sv
// Core model: one divider write per cycle.
// Assumes the bench calls put and idle at falling clock edges.
`timescale 1ns/1ns
`default_nettype none
module core_model
(
   input  wire logic                      clock,
   output var  int_divider_pkg::core_wr_s wr
);
   initial wr = '0;
   task automatic put(int_divider_pkg::reg_sel_e s, logic [31:0] d);
      wr <= '{1'b1, s, d};
      @(negedge clock);
   endtask
   // Idle data inverted so a stale word is never trusted
   task automatic idle(int n);
      wr <= '{1'b0, wr.sel, ~wr.data};
      repeat (n) @(negedge clock);
   endtask
endmodule // core_model
`default_nettype wire

// ===== testbench/divider_chk.sv
// Checks divider ports; bound onto per_core_int_divider.
`timescale 1ns/1ns
`default_nettype none
module divider_chk
(
   input wire logic                      clock,
   input wire logic                      rst,
   input wire int_divider_pkg::core_wr_s wr,
   input wire logic [31:0]               dividend_q,
   input wire logic [31:0]               divisor_q,
   input wire logic [31:0]               quotient_q,
   input wire logic [31:0]               remainder_q,
   input wire logic [31:0]               ctrl_status_q,
   input wire int_divider_pkg::divmod_s  result_q
);
   wire logic rdy = ctrl_status_q[0];
   wire logic opw = wr.valid && wr.sel < int_divider_pkg::SEL_QUOTIENT;
   wire logic ok = divisor_q == 0 ? remainder_q == dividend_q :
      quotient_q * divisor_q + remainder_q == dividend_q;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   sequence s_done; opw ##1 !wr.valid [*8]; endsequence
   a_pack_order: assert property (result_q == {remainder_q, quotient_q})
      else $error("pack");
   a_busy_low: assert property (opw |=> !rdy) else $error("busy");
   a_not_early: assert property (opw ##1 !wr.valid [*7] |=> !rdy)
      else $error("early");
   a_ready_nine: assert property (s_done |=> rdy) else $error("late");
   a_math_ok: assert property (s_done |=> ok) else $error("math");
   a_op_capture: assert property (opw |=>
      ($past(wr.sel[0]) ? divisor_q : dividend_q) == $past(wr.data))
      else $error("capture");
   a_restore_q: assert property (wr.valid &&
      wr.sel == int_divider_pkg::SEL_QUOTIENT |=>
      quotient_q == $past(wr.data)) else $error("restore");
   a_restore_r: assert property (wr.valid &&
      wr.sel == int_divider_pkg::SEL_REMAINDER |=>
      remainder_q == $past(wr.data)) else $error("restore");
   c_div: cover property (s_done ##1 rdy);
   c_zero: cover property (s_done ##1 divisor_q == 0);
   c_back: cover property (opw ##1 opw);
endmodule // divider_chk
bind per_core_int_divider divider_chk chk (.*);
`default_nettype wire

// ===== testbench/per_core_int_divider_bench.sv
// Divider bench: corner and random divides.
// Assumes the checker is bound in and core_model drives the write port.
`timescale 1ns/1ns
`default_nettype none
module per_core_int_divider_bench;
   logic        clock = 0;
   logic        rst = 1;
   logic [63:0] res;
   logic [31:0] csr, dvd, dvs, quo, rem;
   int          fails = 0, n_tests = 0, cyc = 0, i;
   integer      seed = 32'h0000_bbcb;
   int_divider_pkg::core_wr_s wr;
   per_core_int_divider uut (.clock, .rst, .wr, .dividend_q(dvd),
      .divisor_q(dvs), .quotient_q(quo), .remainder_q(rem),
      .ctrl_status_q(csr), .result_q(res));
   core_model core (.clock, .wr);
   initial forever #5 clock = ~clock;
   always @(posedge clock) if (++cyc > 2000) tally_and_finish(1);
   task automatic tally_and_finish(int extra);
      fails += extra;
      $display("checks %0d fails %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic check(string nm, logic [63:0] seen, exp);
      n_tests++;
      fails += int'(seen !== exp);
      if (seen !== exp)
         $display("wrong value %s exp %h got %h", nm, exp, seen);
   endtask
   function automatic logic [63:0] want(logic [31:0] a, b, logic sg);
      if (b == 0) return {a, 32'hFFFF_FFFF};
      if (sg && a == 32'h8000_0000 && &b) return {32'h0000_0000, a};
      if (sg) return {$signed(a) % $signed(b), $signed(a) / $signed(b)};
      return {a % b, a / b};
   endfunction
   task automatic run(logic [31:0] a, b, logic sg, poll);
      core.put(int_divider_pkg::reg_sel_e'({1'b0, sg, 1'b0}), a);
      core.put(int_divider_pkg::reg_sel_e'({1'b0, sg, 1'b1}), b);
      check("operands", {dvd, dvs}, {a, b});
      check("busy", csr[0], 1'b0);
      core.idle(poll ? 1 : 8);
      while (poll && csr[0] !== 1'b1 && cyc < 2000) core.idle(1);
      check("result", res, want(a, b, sg));
      check("words", {rem, quo}, want(a, b, sg));
      check("status", csr, 32'h0000_0003);
   endtask
   initial
   begin
      repeat (16) @(negedge clock);
      rst = 0;
      run(32'h8000_0000, 32'hFFFF_FFFF, 1, 0);
      run(32'h0001_E240, 32'hFFFF_FEBF, 1, 1);
      for (i = 0; i < 40; i++)
         run($random(seed), $random(seed) >> i % 33, i[0], i[1]);
      core.put(int_divider_pkg::SEL_DIVIDEND_S, 32'h0000_0064);
      core.put(int_divider_pkg::SEL_QUOTIENT, 32'h1234_5678);
      core.put(int_divider_pkg::SEL_REMAINDER, 32'h0000_0009);
      core.put(int_divider_pkg::SEL_CTRL_STATUS, 32'h0000_0000);
      core.idle(1);
      check("restore", res, 64'h0000_0009_1234_5678);
      check("kept", csr, 32'h0000_0003);
      rst = 1;
      core.idle(2);
      rst = 0;
      check("reset status", csr, 32'h0000_0001);
      check("reset words", res, 64'h0000_0000_0000_0000);
      run(32'h0000_0064, 32'h0000_0007, 0, 1);
      tally_and_finish(0);
   end
endmodule // per_core_int_divider_bench
`default_nettype wire
